// ---- src/pfm_params.svh ----
// constants for the port 5 i/o and pin mux block
// assumes a 32-bit apb slave on pclk, registers at word offsets below
// Functional notes
// - an eight-bit read/write output latch resets to zero and drives general output pins.
// - the pin readback register is read only and writes to it change nothing.
// - readback bits with direction one return the output latch bit.
// - readback bits with direction zero return the sampled pin level.
// - the two upper pins carry external pwm only when their route-select bit is set.
// - any nonzero timer 1 output-select bit makes pin 7 the timer 1 output, overriding all else.
// - otherwise pin 7 is input, latch output, or pwm 5 when direction 7, route 5 and enable 5 are all set.
// - pin 6 follows the same priority with timer 0, route 4 and pwm enable 4.
// - serial 1 receive enable makes pin 5 its receive input, else direction decides.
// - serial 1 transmit enable makes pin 4 its transmit output, else direction decides.
// - pin 3 is clock input on clock-enable-1, clock output on sync mode or clock-enable-0, else general.
// - serial 0 receive enable makes pin 2 its receive input, else direction decides.
// - serial 0 transmit enable makes pin 1 its transmit output, else direction decides.
// - pin 0 follows serial 0 clock settings the same way as pin 3.
// - direction one is output, zero input; the direction register is write only, resets to zero.
`ifndef PFM_PARAMS_SVH
`define PFM_PARAMS_SVH
`define PFM_OFS_DIR 12'h000
`define PFM_OFS_LATCH 12'h004
`define PFM_OFS_READBACK 12'h008
`define PFM_OFS_PINSEL 12'h00C
`define PFM_RST_DIR 8'h00
`define PFM_RST_LATCH 8'h00
`define PFM_RST_PINSEL 2'h0
`define PFM_BIT_PWM4_ROUTE 0
`define PFM_BIT_PWM5_ROUTE 1
`endif

// ---- src/pfm_pkg.sv ----
// types for the port 5 i/o and pin mux block
// assumes the params header is included by users of the offsets
package pfm_pkg;
  // control bits of one serial channel
  typedef struct packed {
    logic rx_enable_bit;
    logic tx_enable_bit;
    logic sync_mode;
    logic clk_enable0;
    logic clk_enable1;
  } pfm_ser_ctrl_t;
  // pin group: output level and enable
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pfm_pins_t;
endpackage : pfm_pkg

// ---- src/pfm_port_pin_readback.sv ----
// port 5 registers and per-pin function mux behind an apb slave
// assumes peripheral control bits arrive on pclk; pins are asynchronous
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`include "pfm_params.svh"
`timescale 1ns/100ps
`default_nettype none
module pfm_port_pin_readback
  import pfm_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // peripheral control
  input wire logic [3:0] timer0_out_select,
  input wire logic [3:0] timer1_out_select,
  input wire logic timer0_out,
  input wire logic timer1_out,
  input wire logic pwm4_out_en,
  input wire logic pwm5_out_en,
  input wire logic ext_pwm4,
  input wire logic ext_pwm5,
  input wire pfm_ser_ctrl_t ser0_ctrl,
  input wire pfm_ser_ctrl_t ser1_ctrl,
  input wire logic ser0_tx_out,
  input wire logic ser1_tx_out,
  input wire logic ser0_clk_out,
  input wire logic ser1_clk_out,
  // synchronised pin levels to peripherals
  output logic ser0_rx_in,
  output logic ser1_rx_in,
  output logic ser0_clk_in,
  output logic ser1_clk_in,
  // pins
  input wire logic [7:0] pin_in,
  output pfm_pins_t pins
);

  ////////////////////////////////////////////////////////////////
  logic [7:0] port_direction;
  logic [7:0] port_output_latch;
  logic [1:0] pin_select_ctrl0;
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  logic [7:0] port_pin_readback;
  logic [7:0] next_out;
  logic [7:0] next_oe;
  logic wr_en;
  logic rd_en;
  logic addr_ok;

  // apb: zero wait states, full access cycle decides
  assign wr_en = psel && penable && pwrite;
  // read data is loaded in the setup cycle so that it stands through the access phase
  assign rd_en = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign addr_ok = (paddr == `PFM_OFS_DIR) || (paddr == `PFM_OFS_LATCH) ||
                   (paddr == `PFM_OFS_READBACK) || (paddr == `PFM_OFS_PINSEL);
  assign pslverr = psel && penable && !addr_ok;

  ////////////////////////////////////////////////////////////////
  // direction write only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      port_direction <= `PFM_RST_DIR;
    else if (wr_en && paddr == `PFM_OFS_DIR)
      port_direction <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      port_output_latch <= `PFM_RST_LATCH;
    else if (wr_en && paddr == `PFM_OFS_LATCH)
      port_output_latch <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_select_ctrl0 <= `PFM_RST_PINSEL;
    else if (wr_en && paddr == `PFM_OFS_PINSEL)
      pin_select_ctrl0 <= pwdata[1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
    end
    else
    begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  ////////////////////////////////////////////////////////////////
  // driven bits read latch
  assign port_pin_readback = (port_direction & port_output_latch) | (~port_direction & pin_sync);

  // read data; direction reads zero since its value is undefined anyway
  // readback ignores writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (rd_en)
    begin
      case (paddr)
        `PFM_OFS_LATCH: prdata <= {24'h000000, port_output_latch};
        `PFM_OFS_READBACK: prdata <= {24'h000000, port_pin_readback};
        `PFM_OFS_PINSEL: prdata <= {30'h00000000, pin_select_ctrl0};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // peripheral inputs from synchronised pins
  assign ser0_rx_in = pin_sync[2];
  assign ser1_rx_in = pin_sync[5];
  assign ser0_clk_in = pin_sync[0];
  assign ser1_clk_in = pin_sync[3];

  ////////////////////////////////////////////////////////////////
  // pin function mux: each pin picks one owner, peripheral claims ahead of general i/o
  logic tmr1_drives;
  logic tmr0_drives;
  logic pwm5_drives;
  logic pwm4_drives;
  logic ser1_clk_drives;
  logic ser0_clk_drives;
  logic p7_out;
  logic p7_oe;
  logic p6_out;
  logic p6_oe;
  logic p5_out;
  logic p5_oe;
  logic p4_out;
  logic p4_oe;
  logic p3_out;
  logic p3_oe;
  logic p2_out;
  logic p2_oe;
  logic p1_out;
  logic p1_oe;
  logic p0_out;
  logic p0_oe;

  // any timer 1 select bit claims pin 7
  assign tmr1_drives = |timer1_out_select;
  // any timer 0 select bit claims pin 6
  assign tmr0_drives = |timer0_out_select;
  // pwm needs its route bit and its enable
  // and only on a pin set to output
  assign pwm5_drives = port_direction[7] && pin_select_ctrl0[`PFM_BIT_PWM5_ROUTE] && pwm5_out_en;
  assign pwm4_drives = port_direction[6] && pin_select_ctrl0[`PFM_BIT_PWM4_ROUTE] && pwm4_out_en;
  // clock-enable-1 keeps the clock pin an input, so it gates the output modes
  assign ser1_clk_drives = !ser1_ctrl.clk_enable1 && (ser1_ctrl.sync_mode || ser1_ctrl.clk_enable0);
  assign ser0_clk_drives = !ser0_ctrl.clk_enable1 && (ser0_ctrl.sync_mode || ser0_ctrl.clk_enable0);

  // pin 7: timer 1, then pwm 5, then general i/o
  // timer overrides all
  always_comb
  begin
    if (tmr1_drives)
    begin
      p7_out = timer1_out;
      p7_oe = 1'b1;
    end
    else if (pwm5_drives)
    begin
      p7_out = ext_pwm5;
      p7_oe = 1'b1;
    end
    else
    begin
      p7_out = port_output_latch[7];
      p7_oe = port_direction[7];
    end
  end

  // pin 6: timer 0, then pwm 4, then general i/o
  // same priority as pin 7
  always_comb
  begin
    if (tmr0_drives)
    begin
      p6_out = timer0_out;
      p6_oe = 1'b1;
    end
    else if (pwm4_drives)
    begin
      p6_out = ext_pwm4;
      p6_oe = 1'b1;
    end
    else
    begin
      p6_out = port_output_latch[6];
      p6_oe = port_direction[6];
    end
  end

  // pin 5: serial 1 receive input or general i/o; latch kept on out for a clean switch back
  // receive claims pin
  always_comb
  begin
    p5_out = port_output_latch[5];
    if (ser1_ctrl.rx_enable_bit)
      p5_oe = 1'b0;
    else
      p5_oe = port_direction[5];
  end

  // pin 4: serial 1 transmit output or general i/o
  // transmit claims pin
  always_comb
  begin
    if (ser1_ctrl.tx_enable_bit)
    begin
      p4_out = ser1_tx_out;
      p4_oe = 1'b1;
    end
    else
    begin
      p4_out = port_output_latch[4];
      p4_oe = port_direction[4];
    end
  end

  // pin 3: serial 1 clock input, clock output or general i/o
  // clock pin priority
  always_comb
  begin
    p3_out = port_output_latch[3];
    p3_oe = port_direction[3];
    if (ser1_ctrl.clk_enable1)
      p3_oe = 1'b0;
    else if (ser1_clk_drives)
    begin
      p3_out = ser1_clk_out;
      p3_oe = 1'b1;
    end
  end

  // pin 2: serial 0 receive input or general i/o
  // receive claims pin
  always_comb
  begin
    p2_out = port_output_latch[2];
    if (ser0_ctrl.rx_enable_bit)
      p2_oe = 1'b0;
    else
      p2_oe = port_direction[2];
  end

  // pin 1: serial 0 transmit output or general i/o
  // transmit claims pin
  always_comb
  begin
    if (ser0_ctrl.tx_enable_bit)
    begin
      p1_out = ser0_tx_out;
      p1_oe = 1'b1;
    end
    else
    begin
      p1_out = port_output_latch[1];
      p1_oe = port_direction[1];
    end
  end

  // pin 0: serial 0 clock input, clock output or general i/o
  // clock pin priority
  always_comb
  begin
    p0_out = port_output_latch[0];
    p0_oe = port_direction[0];
    if (ser0_ctrl.clk_enable1)
      p0_oe = 1'b0;
    else if (ser0_clk_drives)
    begin
      p0_out = ser0_clk_out;
      p0_oe = 1'b1;
    end
  end

  // gather the pins, msb first
  assign next_out = {p7_out, p6_out, p5_out, p4_out, p3_out, p2_out, p1_out, p0_out};
  assign next_oe = {p7_oe, p6_oe, p5_oe, p4_oe, p3_oe, p2_oe, p1_oe, p0_oe};

  // registered pin drive: one cycle of latency, but glitch-free pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pins <= '0;
    else
    begin
      pins.out <= next_out;
      pins.oe <= next_oe;
    end
  end

endmodule : pfm_port_pin_readback
`default_nettype wire

// ---- testbench/pfm_board.sv ----
// board side of port 5: resolves each pin level
// assumes outside drivers yield where the block drives
`timescale 1ns/100ps
`default_nettype none
module pfm_board
  import pfm_pkg::*;
(
  // block drive, outside level, resolved pins
  input wire pfm_pins_t pins,
  input wire logic [7:0] ext_level,
  output logic [7:0] pin_in
);
  // driven pins carry the block's level, so no contention is modelled
  assign pin_in = (pins.oe & pins.out) | (~pins.oe & ext_level);
endmodule : pfm_board
`default_nettype wire

// ---- testbench/pfm_port_pin_readback_sva.sv ----
// checker for pfm_port_pin_readback pin priorities
// assumes pins follow their controls one edge later
`timescale 1ns/100ps
`default_nettype none
module pfm_port_pin_readback_sva
  import pfm_pkg::*;
(
  // clock, reset, controls, pins
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] timer0_out_select,
  input wire logic [3:0] timer1_out_select,
  input wire logic timer1_out,
  input wire pfm_ser_ctrl_t ser0_ctrl,
  input wire pfm_ser_ctrl_t ser1_ctrl,
  input wire pfm_pins_t pins
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  a_tmr1_wins: assert property (|timer1_out_select |=> pins.oe[7] && pins.out[7] == $past(timer1_out))
    else $error("pin 7 not timer");
  a_tmr0_wins: assert property (|timer0_out_select |=> pins.oe[6])
    else $error("pin 6 not timer");
  a_rx1_input: assert property (ser1_ctrl.rx_enable_bit |=> !pins.oe[5])
    else $error("pin 5 driven");
  a_tx1_drive: assert property (ser1_ctrl.tx_enable_bit |=> pins.oe[4])
    else $error("pin 4 not driven");
  a_ck1_input: assert property (ser1_ctrl.clk_enable1 |=> !pins.oe[3])
    else $error("pin 3 driven");
  a_rx0_input: assert property (ser0_ctrl.rx_enable_bit |=> !pins.oe[2])
    else $error("pin 2 driven");
  a_tx0_drive: assert property (ser0_ctrl.tx_enable_bit |=> pins.oe[1])
    else $error("pin 1 not driven");
  a_ck0_drive: assert property (!ser0_ctrl.clk_enable1 && (ser0_ctrl.sync_mode || ser0_ctrl.clk_enable0) |=> pins.oe[0])
    else $error("pin 0 not driven");
endmodule : pfm_port_pin_readback_sva
bind pfm_port_pin_readback pfm_port_pin_readback_sva sva (.*);
`default_nettype wire

// ---- testbench/tb_top.sv ----
// random bench for pfm_port_pin_readback against a pin-mux model
// assumes pfm_board on the pins and the bound checker
`include "pfm_params.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((e) !== (s)) begin error_cnt++; $display("unexpected %s %h %h", n, e, s); end end
module tb_top
  import pfm_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err, pready, pslverr;
  logic ser0_rx_in, ser1_rx_in, ser0_clk_in, ser1_clk_in, timer0_out, timer1_out, pwm4_out_en, pwm5_out_en;
  logic ext_pwm4, ext_pwm5, ser0_tx_out, ser1_tx_out, ser0_clk_out, ser1_clk_out;
  logic [3:0] timer0_out_select, timer1_out_select;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [63:0] q = 0;
  logic [7:0] pin_in, ext_level, dir, lat, eo, ev, rp;
  pfm_ser_ctrl_t ser0_ctrl, ser1_ctrl;
  pfm_pins_t pins;
  int error_cnt = 0, total_checks = 0, seed = 37279;
  // peripheral controls from one random word; timer selects masked so other modes show
  assign {timer0_out_select, timer1_out_select, ser0_ctrl, ser1_ctrl, timer0_out, timer1_out, pwm4_out_en, pwm5_out_en,
    ext_pwm4, ext_pwm5, ser0_tx_out, ser1_tx_out, ser0_clk_out, ser1_clk_out, ext_level} = {q[35:32] & {4{q[40]}},
    q[31:28] & {4{q[41]}}, q[27:0]};
  pfm_port_pin_readback dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer0_out_select(timer0_out_select),
    .timer1_out_select(timer1_out_select), .timer0_out(timer0_out), .timer1_out(timer1_out),
    .pwm4_out_en(pwm4_out_en), .pwm5_out_en(pwm5_out_en), .ext_pwm4(ext_pwm4), .ext_pwm5(ext_pwm5),
    .ser0_ctrl(ser0_ctrl), .ser1_ctrl(ser1_ctrl), .ser0_tx_out(ser0_tx_out), .ser1_tx_out(ser1_tx_out),
    .ser0_clk_out(ser0_clk_out), .ser1_clk_out(ser1_clk_out), .ser0_rx_in(ser0_rx_in), .ser1_rx_in(ser1_rx_in),
    .ser0_clk_in(ser0_clk_in), .ser1_clk_in(ser1_clk_in), .pin_in(pin_in), .pins(pins));
  pfm_board board (.pins(pins), .ext_level(ext_level), .pin_in(pin_in));
  // 100 MHz clock
  always #5 pclk = ~pclk;
  ////////////////////////////////////////
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
  endtask : apb
  // verdict
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test
  // hang guard
  initial
  begin
    #50000;
    error_cnt++;
    finish_test();
  end
  // reset, then random settings against the model
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    `CHK("oe", 8'h0, pins.oe)
    apb(1'h0, 12'h010, 32'h0);
    `CHK("slverr", 1'h1, err)
    repeat (40)
    begin
      apb(1'h1, `PFM_OFS_DIR, $random(seed));
      dir = pwdata[7:0];
      apb(1'h1, `PFM_OFS_LATCH, $random(seed));
      lat = pwdata[7:0];
      apb(1'h1, `PFM_OFS_READBACK, ~pwdata);
      apb(1'h1, `PFM_OFS_PINSEL, $random(seed));
      q <= {$random(seed), $random(seed)};
      repeat (2) @(posedge pclk);
      eo = dir;
      ev = lat;
      ev[7] = pwdata[1] && pwm5_out_en ? ext_pwm5 : lat[7];
      ev[6] = pwdata[0] && pwm4_out_en ? ext_pwm4 : lat[6];
      if (|timer1_out_select) {eo[7], ev[7]} = {1'h1, timer1_out};
      if (|timer0_out_select) {eo[6], ev[6]} = {1'h1, timer0_out};
      if (ser1_ctrl.tx_enable_bit) {eo[4], ev[4]} = {1'h1, ser1_tx_out};
      if (ser0_ctrl.tx_enable_bit) {eo[1], ev[1]} = {1'h1, ser0_tx_out};
      if (ser1_ctrl.sync_mode || ser1_ctrl.clk_enable0) {eo[3], ev[3]} = {1'h1, ser1_clk_out};
      if (ser0_ctrl.sync_mode || ser0_ctrl.clk_enable0) {eo[0], ev[0]} = {1'h1, ser0_clk_out};
      eo &= ~{2'h0, ser1_ctrl.rx_enable_bit, 1'h0, ser1_ctrl.clk_enable1, ser0_ctrl.rx_enable_bit, 1'h0,
        ser0_ctrl.clk_enable1};
      rp = (eo & ev) | (~eo & ext_level);
      `CHK("oe", eo, pins.oe)
      `CHK("out", ev & eo, pins.out & eo)
      repeat (2) @(posedge pclk);
      apb(1'h0, `PFM_OFS_READBACK, 32'h0);
      `CHK("readback", {24'h0, (dir & lat) | (~dir & rp)}, rd)
      `CHK("periph_in", {rp[5], rp[3], rp[2], rp[0]}, {ser1_rx_in, ser1_clk_in, ser0_rx_in, ser0_clk_in})
      apb(1'h0, `PFM_OFS_LATCH, 32'h0);
      `CHK("latch", {24'h0, lat}, rd)
    end
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
